// ### pkg/rqf_pkg.sv
/*
 receive queue frame formatter package: entry layout, status bit positions,
 thresholds, register map. assumes one system clock and an APB register bus.
*/
`default_nettype none
package rqf_pkg;
	localparam int unsigned MEM_BYTES      = 4096;
	localparam int unsigned MEM_WORDS      = MEM_BYTES / 2;
	localparam int unsigned AW             = 11;
	localparam int unsigned MAX_DATA       = 1916;
	localparam logic [10:0] OFF_STATUS     = 11'h000;
	localparam logic [10:0] OFF_COUNT      = 11'h002;
	localparam logic [10:0] OFF_DATA       = 11'h004;
	localparam int unsigned FCS_BYTES      = 4;
	localparam int unsigned BIT_VALID      = 15;
	localparam int unsigned BIT_PORT_HI    = 9;
	localparam int unsigned BIT_PORT_LO    = 8;
	localparam int unsigned BIT_BCAST      = 7;
	localparam int unsigned BIT_GROUP      = 6;
	localparam int unsigned BIT_SINGLE     = 5;
	localparam int unsigned BIT_LTYPE      = 3;
	localparam int unsigned BIT_OVERSIZE   = 2;
	localparam int unsigned BIT_SHORT      = 1;
	localparam int unsigned BIT_CRC        = 0;
	localparam logic [15:0] LTYPE_LIMIT    = 16'h05DC;
	localparam logic [10:0] OVERSIZE_LIMIT = 11'h5EE;
	localparam logic [1:0]  PORT_ONE       = 2'h1;
	localparam logic [1:0]  PORT_TWO       = 2'h2;
	localparam logic [11:0] REG_CTRL       = 12'h000;
	localparam logic [11:0] REG_STATUS     = 12'h004;
	localparam logic [11:0] REG_COUNT      = 12'h008;
	localparam logic [11:0] REG_FILL       = 12'h00C;
	localparam logic [11:0] REG_DATA       = 12'h010;
	localparam logic [11:0] REG_RELEASE    = 12'h014;
	localparam logic [1:0]  CTRL_RESET     = 2'h0;
	localparam int unsigned CTRL_STRIP     = 0;
	localparam int unsigned CTRL_PASSBAD   = 1;

	typedef struct packed {
		logic       valid;
		logic [1:0] port;
		logic       bcast;
		logic       group;
		logic       single;
		logic       ltype;
		logic       oversize;
		logic       short_f;
		logic       crc_err;
	} rqf_status_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DATA = 4'h2,
		ST_STAT = 4'h4,
		ST_CNT  = 4'h8
	} rqf_state_e;
endpackage
`default_nettype wire

// ### logic/rqf_apb_slave.sv
/*
 apb register slave: control bits, current-entry status readout, data pop.
 assumes an apb master on sys_clk_i; answers in the access cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module rqf_apb_slave (
	input  wire logic        sys_clk_i,   // system clock
	input  wire logic        rst_i,       // sync reset, high
	input  wire logic        psel_i,      // apb select
	input  wire logic        penable_i,   // apb enable
	input  wire logic        pwrite_i,    // apb write
	input  wire logic [11:0] paddr_i,     // apb byte address
	input  wire logic [31:0] pwdata_i,    // apb write data
	output var  logic [31:0] prdata_o,    // apb read data
	output logic             pready_o,    // apb ready
	output logic             pslverr_o,   // apb error
	input  wire logic [15:0] status_i,    // head entry status word
	input  wire logic [15:0] count_i,     // head entry count word
	input  wire logic [15:0] fill_i,      // used words
	input  wire logic [15:0] rdata_i,     // word at read pointer
	output logic [1:0]       ctrl_o,      // strip, pass bad
	output logic             pop_o,       // data word read
	output logic             release_o    // drop head entry
);
	import rqf_pkg::*;
	logic       acc;
	logic       hit;
	logic [1:0] ctrl;

	assign acc       = psel_i & penable_i;
	assign pready_o  = 1'b1;
	assign hit       = paddr_i == REG_CTRL || paddr_i == REG_STATUS || paddr_i == REG_COUNT
		|| paddr_i == REG_FILL || paddr_i == REG_DATA || paddr_i == REG_RELEASE;
	assign pslverr_o = acc & ~hit;
	assign pop_o     = acc & ~pwrite_i & (paddr_i == REG_DATA);
	assign release_o = acc & pwrite_i & (paddr_i == REG_RELEASE);
	assign ctrl_o    = ctrl;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			ctrl <= CTRL_RESET;
		else if (acc && pwrite_i && paddr_i == REG_CTRL)
			ctrl <= pwdata_i[1:0];
	end

	// read data captured in the setup cycle, so it comes from a flip-flop
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			prdata_o <= 32'h0;
		else if (psel_i && !penable_i) begin
			case (paddr_i)
				REG_CTRL:   prdata_o <= {30'h0, ctrl};
				REG_STATUS: prdata_o <= {16'h0, status_i};
				REG_COUNT:  prdata_o <= {16'h0, count_i};
				REG_FILL:   prdata_o <= {16'h0, fill_i};
				REG_DATA:   prdata_o <= {16'h0, rdata_i};
				default:    prdata_o <= 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### logic/rqf_formatter.sv
/*
 receive queue frame formatter: writes status, count and packed data of each kept
 frame (good or pass-bad, with ring space, at most 1916 bytes) into a 4 KB ring and lets the host read entries over apb.
 assumes the mac side delivers bytes with start/last and end-of-frame flags.
*/
`timescale 1ns/10ps
`default_nettype none
module rqf_formatter (
	input  wire logic        sys_clk_i,    // system clock
	input  wire logic        rst_i,        // sync reset, high
	input  wire logic        rx_valid_i,   // byte strobe from mac
	input  wire logic [7:0]  rx_byte_i,    // frame byte
	input  wire logic        rx_first_i,   // first byte of frame
	input  wire logic        rx_last_i,    // last byte incl. fcs
	input  wire logic [1:0]  rx_port_i,    // ingress port code
	input  wire logic        rx_crc_bad_i, // fcs wrong, with last
	input  wire logic        rx_runt_i,    // collision or early end, with last
	output logic             rx_drop_o,    // frame discarded, pulse
	input  wire logic        psel_i,       // apb select
	input  wire logic        penable_i,    // apb enable
	input  wire logic        pwrite_i,     // apb write
	input  wire logic [11:0] paddr_i,      // apb address
	input  wire logic [31:0] pwdata_i,     // apb write data
	output var  logic [31:0] prdata_o,     // apb read data
	output logic             pready_o,     // apb ready
	output logic             pslverr_o,    // apb error
	output var  rqf_pkg::rqf_status_s head_status_o // head entry status
);
	import rqf_pkg::*;

	// ****************************************
	// memory and pointers
	// ****************************************
	logic [15:0]   mem [MEM_WORDS];
	logic [AW-1:0] wr_base;
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_head;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   used;
	logic [AW:0]   entry_words;
	logic [AW:0]   next_used;
	rqf_state_e    state;
	logic [1:0]    ctrl;
	logic          pop;
	logic          rel;
	logic [15:0]   rdata;
	logic [15:0]   head_stat;
	logic [15:0]   head_cnt;
	logic          head_ok;

	// ****************************************
	// frame classification
	// ****************************************
	logic [10:0]   nbytes;
	logic [10:0]   stored;
	logic [31:0]   tail;
	logic [7:0]    lo_byte;
	logic          have_lo;
	logic          bcast;
	logic          group;
	logic [15:0]   ltype;
	logic          overflow;
	logic          crc_bad;
	logic          runt;
	logic [1:0]    port;
	logic          bad;
	logic          commit;
	logic [15:0]   stat_word;
	logic [10:0]   keep_bytes;
	logic          space_ok;

	assign keep_bytes = ctrl[CTRL_STRIP] ? stored - 11'(FCS_BYTES) : stored;
	assign bad        = (nbytes > OVERSIZE_LIMIT) | crc_bad | runt;
	assign commit     = ~overflow & (~bad | ctrl[CTRL_PASSBAD]);
	assign space_ok   = used + 12'(MAX_DATA / 2 + 3) <= 12'(MEM_WORDS);
	assign stat_word  = {1'b1, 5'h00, port, bcast, group, ~group, 1'b0,
		(ltype > LTYPE_LIMIT), (nbytes > OVERSIZE_LIMIT), runt, crc_bad};
	assign entry_words = 12'(2) + 12'((keep_bytes + 11'h1) >> 1);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			nbytes <= 11'h0;
			stored <= 11'h0;
			tail <= 32'h0;
			lo_byte <= 8'h0;
			have_lo <= 1'b0;
			bcast <= 1'b0;
			group <= 1'b0;
			ltype <= 16'h0;
			overflow <= 1'b0;
			crc_bad <= 1'b0;
			runt <= 1'b0;
			port <= 2'h0;
			wr_ptr <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (rx_valid_i && rx_first_i) begin
						state <= ST_DATA;
						nbytes <= 11'h1;
						stored <= 11'h0;
						tail <= {24'h0, rx_byte_i};
						lo_byte <= rx_byte_i;
						have_lo <= 1'b1;
						bcast <= rx_byte_i == 8'hFF;
						group <= rx_byte_i[0];
						port <= rx_port_i;
						overflow <= ~space_ok;
						ltype <= 16'h0;
						wr_ptr <= wr_base + (OFF_DATA >> 1);
					end
				end
				ST_DATA: begin
					if (rx_valid_i) begin
						if (nbytes != 11'h7FF)
							nbytes <= nbytes + 11'h1;
						tail <= {tail[23:0], rx_byte_i};
						if (nbytes < 11'h6)
							bcast <= bcast & (rx_byte_i == 8'hFF);
						if (nbytes == 11'hC)
							ltype[15:8] <= rx_byte_i;
						if (nbytes == 11'hD)
							ltype[7:0] <= rx_byte_i;
						if (nbytes >= 11'(MAX_DATA))
							overflow <= 1'b1;
						if (have_lo) begin
							if (nbytes < 11'(MAX_DATA)) begin
								mem[wr_ptr] <= {rx_byte_i, lo_byte};
								wr_ptr <= wr_ptr + 11'h1;
								stored <= nbytes + 11'h1;
							end
							have_lo <= 1'b0;
						end else begin
							lo_byte <= rx_byte_i;
							have_lo <= 1'b1;
						end
						if (rx_last_i) begin
							state <= ST_STAT;
							crc_bad <= rx_crc_bad_i;
							runt <= rx_runt_i;
						end
					end
				end
				ST_STAT: begin
					if (have_lo && nbytes <= 11'(MAX_DATA)) begin
						mem[wr_ptr] <= {8'h00, lo_byte};
						stored <= nbytes;
					end
					have_lo <= 1'b0;
					state <= ST_CNT;
				end
				ST_CNT: begin
					if (commit) begin
						mem[wr_base] <= stat_word;
						mem[wr_base + (OFF_COUNT >> 1)] <= {5'h00, keep_bytes};
					end
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign rx_drop_o = (state == ST_CNT) & ~commit;

	// ****************************************
	// ring bookkeeping
	// ****************************************
	always_comb begin
		next_used = used;
		if (state == ST_CNT && commit)
			next_used = next_used + entry_words;
		if (rel && head_ok)
			next_used = next_used - (12'(2) + 12'((head_cnt[10:0] + 11'h1) >> 1));
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			used <= '0;
			wr_base <= '0;
			rd_head <= '0;
			rd_ptr <= OFF_DATA >> 1;
		end else begin
			used <= next_used;
			if (state == ST_CNT && commit)
				wr_base <= wr_base + entry_words[AW-1:0];
			if (rel && head_ok) begin
				rd_head <= rd_head + 11'(2 + ((head_cnt[10:0] + 11'h1) >> 1));
				rd_ptr <= rd_head + 11'(4 + ((head_cnt[10:0] + 11'h1) >> 1));
			end else if (pop)
				rd_ptr <= rd_ptr + 11'h1;
		end
	end

	// ****************************************
	// head entry readout
	// ****************************************
	assign head_ok   = used != '0;
	assign head_stat = head_ok ? mem[rd_head] : 16'h0000;
	assign head_cnt  = head_ok ? mem[rd_head + (OFF_COUNT >> 1)] : 16'h0000;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			rdata <= 16'h0;
		else
			rdata <= mem[rd_ptr];
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			head_status_o <= '0;
		else
			head_status_o <= '{valid: head_stat[BIT_VALID],
				port: head_stat[BIT_PORT_HI:BIT_PORT_LO], bcast: head_stat[BIT_BCAST],
				group: head_stat[BIT_GROUP], single: head_stat[BIT_SINGLE],
				ltype: head_stat[BIT_LTYPE], oversize: head_stat[BIT_OVERSIZE],
				short_f: head_stat[BIT_SHORT], crc_err: head_stat[BIT_CRC]};
	end

	rqf_apb_slave u_apb (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.pwdata_i  (pwdata_i),
		.prdata_o  (prdata_o),
		.pready_o  (pready_o),
		.pslverr_o (pslverr_o),
		.status_i  (head_stat),
		.count_i   (head_cnt),
		.fill_i    ({4'h0, used}),
		.rdata_i   (rdata),
		.ctrl_o    (ctrl),
		.pop_o     (pop),
		.release_o (rel)
	);

	// ****************************************
	// checks
	// ****************************************
	a_valid_tied: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		head_ok == head_stat[BIT_VALID]) else $error("valid bit mismatch");
	a_port_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		head_ok |-> (head_stat[BIT_PORT_HI:BIT_PORT_LO] == PORT_ONE
		|| head_stat[BIT_PORT_HI:BIT_PORT_LO] == PORT_TWO)) else $error("port code");
	a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		head_stat[14:10] == 5'h0 && head_stat[4] == 1'b0 && head_cnt[15:11] == 5'h0)
		else $error("reserved bits set");
	a_group_bcast: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		head_stat[BIT_BCAST] |-> head_stat[BIT_GROUP]) else $error("bcast not group");
	a_single_group: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		head_ok |-> head_stat[BIT_SINGLE] != head_stat[BIT_GROUP])
		else $error("unicast flag wrong");
	a_bad_dropped: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state == ST_CNT && bad && !ctrl[CTRL_PASSBAD]) |=> $stable(wr_base))
		else $error("bad frame kept");
	a_size_limit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		head_ok |-> head_cnt[10:0] <= 11'(MAX_DATA)) else $error("entry too big");
	a_commit_adv: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state == ST_CNT && commit) |=> wr_base == $past(wr_base) + $past(entry_words[AW-1:0]))
		else $error("write base not advanced");
	a_used_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		used <= 12'(MEM_WORDS)) else $error("ring overrun");
	c_frame_kept: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		state == ST_CNT && commit);
	c_frame_drop: cover property (@(posedge sys_clk_i) disable iff (rst_i) rx_drop_o);
	c_release: cover property (@(posedge sys_clk_i) disable iff (rst_i) rel && head_ok);
endmodule
`default_nettype wire

// ### tb/rqf_host_model.sv
/*
 apb host model that reads the receive queue over the register bus.
 assumes every task call starts just after a rising edge of sys_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module rqf_host_model (
	input  wire logic        sys_clk_i, // system clock
	input  wire logic [31:0] prdata_i,  // apb read data
	input  wire logic        pready_i,  // apb ready
	input  wire logic        pslverr_i, // apb error
	output logic             psel_o,    // apb select
	output logic             penable_o, // apb enable
	output logic             pwrite_o,  // apb write
	output logic [11:0]      paddr_o,   // apb address
	output logic [31:0]      pwdata_o   // apb write data
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0;
	end

	// one transfer, then one idle cycle so data reads never run back to back
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge sys_clk_i);
		penable_o <= 1'b1;
		@(posedge sys_clk_i);
		while (pready_i !== 1'b1) begin
			@(posedge sys_clk_i);
		end
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		@(posedge sys_clk_i);
	endtask
endmodule
`default_nettype wire

// ### tb/tb_rqf_formatter.sv
/*
 bench for the receive queue formatter: random frames on the byte stream,
 entries read back over apb by the host model. assumes rqf_pkg.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_rqf_formatter;
	import rqf_pkg::*;
	logic        sys_clk_i, rst_i, rx_valid, rx_first, rx_last, rx_crc, rx_runt, rx_drop;
	logic        psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, rs;
	logic [7:0]  rx_byte;
	logic [1:0]  rx_port;
	logic [7:0]  fr[$], fa[$], fb[$];
	rqf_status_s head;
	int          failures, n_compared;

	rqf_formatter u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid),
		.rx_byte_i(rx_byte), .rx_first_i(rx_first), .rx_last_i(rx_last),
		.rx_port_i(rx_port), .rx_crc_bad_i(rx_crc), .rx_runt_i(rx_runt),
		.rx_drop_o(rx_drop), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .head_status_o(head));
	rqf_host_model u_host (.sys_clk_i(sys_clk_i), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));

	function automatic logic [31:0] rnd();
		for (int i = 0; i < 8; i++) rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
		return rs;
	endfunction

	// expected status word of the frame held in fr
	function automatic logic [15:0] est(input logic [1:0] p, input logic cb, input logic rn);
		logic b;
		b = &{fr[0], fr[1], fr[2], fr[3], fr[4], fr[5]};
		return {1'b1, 5'h00, p, b, fr[0][0], !fr[0][0], 1'b0,
			{fr[12], fr[13]} > LTYPE_LIMIT, fr.size() > 1518, rn, cb};
	endfunction

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		u_host.xfer(1'b0, a, 32'h0, d, e);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		u_host.xfer(1'b1, a, d, x, e);
	endtask

	// k: 0 unicast, 1 multicast, 2 broadcast destination
	task automatic mk(input int k, input int len);
		logic [31:0] v;
		logic [15:0] ty;
		v = rnd();
		ty = v[1:0] == 2'h0 ? 16'h0800 : v[1:0] == 2'h1 ? 16'h05DC :
			v[1:0] == 2'h2 ? 16'h05DD : {5'h00, v[26:16]};
		fr.delete();
		for (int i = 0; i < len; i++) fr.push_back(8'(rnd()));
		if (k == 2) for (int i = 0; i < 6; i++) fr[i] = 8'hFF;
		else fr[0][0] = (k == 1);
		fr[12] = ty[15:8];
		fr[13] = ty[7:0];
	endtask

	task automatic send(input logic [1:0] p, input logic cb, input logic rn, output logic dr);
		dr = 1'b0;
		for (int i = 0; i < fr.size(); i++) begin
			rx_valid <= 1'b1;
			rx_byte <= fr[i];
			rx_first <= (i == 0);
			rx_last <= (i == fr.size() - 1);
			rx_port <= p;
			rx_crc <= cb;
			rx_runt <= rn;
			@(posedge sys_clk_i);
		end
		rx_valid <= 1'b0;
		rx_first <= 1'b0;
		rx_last <= 1'b0;
		repeat (4) begin
			@(posedge sys_clk_i);
			if (rx_drop === 1'b1) dr = 1'b1;
		end
	endtask

	task automatic chk_entry(input logic [1:0] p, input logic cb, input logic rn, input logic st);
		logic [31:0] m;
		logic [15:0] x;
		int n;
		n = fr.size() - (st ? 4 : 0);
		x = est(p, cb, rn);
		m = rn ? 32'hFFFF_FFF7 : 32'hFFFF_FFFF;
		rd(REG_STATUS, r);
		`CHK(r & m, {16'h0, x} & m)
		if (!rn) `CHK(head, {x[15], x[9:5], x[3:0]})
		rd(REG_COUNT, r);
		`CHK(r, {21'h0, 11'(n)})
		for (int i = 0; i < n; i += 2) begin
			rd(REG_DATA, r);
			m = (st && i + 1 >= n) ? 32'hFFFF_00FF : 32'hFFFF_FFFF;
			`CHK(r & m, {16'h0, (i + 1 < n) ? fr[i + 1] : 8'h00, fr[i]} & m)
		end
		wr(REG_RELEASE, rnd());
	endtask

	task automatic run(input int k, input logic [1:0] p, input logic cb, input logic rn,
		input logic pb, input logic st, input int len);
		logic dr, xd;
		wr(REG_CTRL, {30'h0, pb, st});
		rd(REG_CTRL, r);
		`CHK(r, {30'h0, pb, st})
		mk(k, len);
		send(p, cb, rn, dr);
		xd = (cb | rn | (len > 1518)) & !pb;
		`CHK(dr, xd)
		if (!xd) chk_entry(p, cb, rn, st);
		rd(REG_STATUS, r);
		`CHK(r, 32'h0)
	endtask

	task automatic stop_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		#900_000;
		failures++;
		stop_test;
	end

	//********************************************************************
	// main sequence
	//********************************************************************
	initial begin
		logic dr;
		{rx_valid, rx_first, rx_last, rx_crc, rx_runt} = 5'h00;
		rx_byte = 8'h00;
		rx_port = 2'h1;
		rs = 32'h2a4ce16c;
		rst_i = 1'b1;
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		rd(REG_CTRL, r);
		`CHK(r, 32'h0)
		rd(REG_STATUS, r);
		`CHK(r, 32'h0)
		rd(REG_FILL, r);
		`CHK(r, 32'h0)
		u_host.xfer(1'b1, 12'h020, rnd(), r, e);
		`CHK(e, 1'b1)
		u_host.xfer(1'b0, 12'h020, 32'h0, r, e);
		`CHK({e, r}, 33'h1_0000_0000)
		run(0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 60 + int'(rnd() % 64));
		run(2, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 64);
		run(1, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 71);
		run(0, 2'h2, 1'b0, 1'b1, 1'b1, 1'b1, 40);
		run(1, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1521);
		run(0, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1518);
		run(0, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 80);
		run(0, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 30);
		run(0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1519);
		wr(REG_CTRL, 32'h0);
		mk(0, 64);
		send(2'h1, 1'b0, 1'b0, dr);
		fa = fr;
		mk(1, 61);
		send(2'h2, 1'b0, 1'b0, dr);
		fb = fr;
		rd(REG_FILL, r);
		`CHK(r, 32'(4 + (fa.size() + 1) / 2 + (fb.size() + 1) / 2))
		fr = fa;
		chk_entry(2'h1, 1'b0, 1'b0, 1'b0);
		fr = fb;
		chk_entry(2'h2, 1'b0, 1'b0, 1'b0);
		rd(REG_STATUS, r);
		`CHK(r, 32'h0)
		// reset in mid-run with an entry queued and both control bits set
		wr(REG_CTRL, 32'h3);
		mk(0, 64);
		send(2'h1, 1'b0, 1'b0, dr);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		rd(REG_FILL, r);
		`CHK(r, 32'h0)
		rd(REG_CTRL, r);
		`CHK(r, 32'h0)
		`CHK(head, 10'h000)
		rd(REG_STATUS, r);
		`CHK(r, 32'h0)
		stop_test;
	end
endmodule
`default_nettype wire
